// >>> lsc_pkg.sv
// Package: constants and types of the laser serial command interpreter
//
// Functional notes
// - Each of two modules keeps three uninterpreted 20-character text strings.
// - String access names module and string; a write stores, a read reports.
// - Measured current of the chosen module is reported in milliamperes.
// - Measured light of the chosen module is reported as 0 to 65535.
// - On-time is reported in whole hours and saturates at 11930.
// - Hour count lives in each module's own non-volatile storage.
// - Aiming beam: 0 off, 1 on, query reports; off after power-up.
// - Current changes ramp gradually unless quick mode applies them at once.
// - Quick current mode: 0 off, 1 on, query reports; off after power-up.
// - No command within the auto-off interval turns output off and posts status.
// - Auto-off interval is 0 to 65535 seconds; zero disables the shutdown.
// - Auto-off interval is kept in non-volatile storage across power cycles.
// - Foot-pedal mode lets the pedal contact switch the output on and off.
// - Firmware version query takes no parameter and returns a version string.
// - Status code 7 means the inactivity timer turned the output off.
// - With several errors active only the lowest status code is reported.

`default_nettype none

package lsc_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned SECOND_NS     = 1_000_000_000;
    localparam int unsigned SECOND_CYC    = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned RAMP_STEP_NS  = 10_000;
    localparam int unsigned RAMP_STEP_CYC = RAMP_STEP_NS / CLK_PERIOD_NS;
    localparam logic [8:0]  RAMP_LAST     = 9'(RAMP_STEP_CYC - 1);
    localparam int unsigned HOUR_SECONDS  = 3600;
    localparam logic [11:0] HOUR_SEC_LAST = 12'(HOUR_SECONDS - 1);
    localparam logic [13:0] HOURS_MAX     = 14'h2E9A;

    // ==========================================================
    // Strings
    localparam int unsigned STR_WORDS_EACH = 5;
    localparam int unsigned STR_PER_MOD    = 3;
    localparam int unsigned STR_WORDS      = 2 * STR_PER_MOD * STR_WORDS_EACH;

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_AUTOOFF  = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_CURSET   = 8'h0C;
    localparam logic [7:0] ADDR_CURDRV   = 8'h10;
    localparam logic [7:0] ADDR_MEASCUR0 = 8'h14;
    localparam logic [7:0] ADDR_MEASCUR1 = 8'h18;
    localparam logic [7:0] ADDR_LIGHT0   = 8'h1C;
    localparam logic [7:0] ADDR_LIGHT1   = 8'h20;
    localparam logic [7:0] ADDR_HOURS0   = 8'h24;
    localparam logic [7:0] ADDR_HOURS1   = 8'h28;
    localparam logic [7:0] ADDR_FWVER    = 8'h2C;
    localparam logic [7:0] ADDR_IRQSTAT  = 8'h30;
    localparam logic [7:0] ADDR_IRQMASK  = 8'h34;
    localparam logic [7:0] ADDR_STR      = 8'h40;
    localparam logic [7:0] ADDR_STR_LAST = 8'hB4;

    // ==========================================================
    // Field positions and reset values
    localparam int unsigned CTRL_AIM    = 0;
    localparam int unsigned CTRL_QUICK  = 1;
    localparam int unsigned CTRL_PEDAL  = 2;
    localparam int unsigned CTRL_OUT    = 3;
    localparam int unsigned IRQ_AUTOOFF = 0;
    localparam int unsigned IRQ_PEDAL   = 1;
    localparam logic [2:0]  STATUS_OK    = 3'h0;
    localparam logic [2:0]  STATUS_TIMER = 3'h7;
    localparam logic [31:0] FW_VERSION   = 32'h56303130; // Arbitrary version word

    typedef enum {
        BUS_IDLE,
        BUS_WRITE,
        BUS_RDWAIT,
        BUS_RDDONE
    } lsc_bus_t;

endpackage

`default_nettype wire

// >>> lsc_hour_counter.sv
// Per-module diode on-time hour counter with load and write-back
`default_nettype none

module lsc_hour_counter (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // Timing and activity
    input  wire logic        secTick,
    input  wire logic        diodeOn,
    // Module storage
    input  wire logic        nvLoad,
    input  wire logic [13:0] nvHours,
    output logic      [13:0] hours_q,
    output logic             nvWrite_q
);

    logic [11:0] secCnt_q;
    logic        hourStep;

    assign hourStep = secTick && diodeOn && (hours_q != lsc_pkg::HOURS_MAX)
                      && (secCnt_q == lsc_pkg::HOUR_SEC_LAST);

    // ==========================================================
    // Seconds within the current hour
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            secCnt_q <= 12'h000;
        end else if (clkEn) begin
            if (nvLoad || hourStep) begin
                secCnt_q <= 12'h000;
            end else if (secTick && diodeOn && hours_q != lsc_pkg::HOURS_MAX) begin
                secCnt_q <= secCnt_q + 12'h001;
            end
        end
    end

    // ==========================================================
    // Hour count, fresh from the module's own storage on load
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hours_q   <= 14'h0000;
            nvWrite_q <= 1'b0;
        end else if (clkEn) begin
            nvWrite_q <= hourStep;
            if (nvLoad) begin
                // Corrupt storage above the ceiling still reports the ceiling
                hours_q <= (nvHours > lsc_pkg::HOURS_MAX) ? lsc_pkg::HOURS_MAX : nvHours;
            end else if (hourStep) begin
                hours_q <= hours_q + 14'h0001;
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    hourSat_a: assert property (hours_q == lsc_pkg::HOURS_MAX && !nvLoad |=> hours_q == lsc_pkg::HOURS_MAX)
        else $error("hour count left its ceiling");
    hourLoad_a: assert property (nvLoad && clkEn && nvHours <= lsc_pkg::HOURS_MAX |=> hours_q == $past(nvHours))
        else $error("hour count not loaded from module storage");

endmodule

`default_nettype wire

// >>> lsc_cmd_core.sv
// Command interpreter core: AHB-Lite registers, auto-off, pedal, ramp, strings
`default_nettype none

module lsc_cmd_core #(
    parameter int unsigned SEC_CYCLES = lsc_pkg::SECOND_CYC
) (
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Interrupt
    output logic             irq,
    // Laser controls
    output logic             laserOut_q,
    output logic             aimBeam_q,
    output logic             quickMode_q,
    output logic      [15:0] curDrive_q,
    // Measurements and error conditions
    input  wire logic [15:0] measCur0,
    input  wire logic [15:0] measCur1,
    input  wire logic [15:0] measLight0,
    input  wire logic [15:0] measLight1,
    input  wire logic [5:0]  errIn,
    // Foot pedal pin
    input  wire logic        pedalIn,
    // Auto-off interval storage
    input  wire logic [15:0] nvAutoOff,
    output logic             nvAutoOffWr_q,
    output logic      [15:0] autoOff_q,
    // Module hour storage
    input  wire logic [1:0]  modSwap,
    input  wire logic [13:0] modNvHours0,
    input  wire logic [13:0] modNvHours1,
    output logic      [1:0]  modNvWrite,
    output logic      [13:0] hours0,
    output logic      [13:0] hours1
);

    localparam logic [25:0] SEC_LAST = 26'(SEC_CYCLES - 1);

    lsc_pkg::lsc_bus_t busState_q;
    logic [7:0]  regAddr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rdMux;
    logic        addrTake;
    logic        wrEn;
    logic        cmdSeen;
    logic        strHit;
    logic [5:0]  strIdx;
    logic [31:0] strMem [lsc_pkg::STR_WORDS];
    logic        pedalMode_q;
    logic        timerErr_q;
    logic        nvLoaded_q;
    logic [15:0] curSet_q;
    logic [15:0] idleSec_q;
    logic [25:0] secCnt_q;
    logic [8:0]  rampCnt_q;
    logic        secTick;
    logic        rampTick;
    logic        autoOffFire;
    logic        pedalMeta_q;
    logic        pedalSync_q;
    logic        pedalPrev_q;
    logic        pedalRise;
    logic        pedalFall;
    logic [2:0]  statusCode;
    logic [1:0]  irqStat_q;
    logic [1:0]  irqMask_q;
    logic [1:0]  irqEvt;
    logic [1:0]  modLoad;

    // ==========================================================
    // AHB-Lite slave: writes take no wait, reads insert one
    assign addrTake  = hsel && hready && htrans[1];
    assign hreadyout = (busState_q != lsc_pkg::BUS_RDWAIT);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign wrEn      = clkEn && (busState_q == lsc_pkg::BUS_WRITE);
    assign cmdSeen   = clkEn && (busState_q == lsc_pkg::BUS_WRITE
                                 || busState_q == lsc_pkg::BUS_RDWAIT);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busState_q <= lsc_pkg::BUS_IDLE;
            regAddr_q  <= 8'h00;
        end else if (clkEn) begin
            case (busState_q)
                lsc_pkg::BUS_RDWAIT: begin
                    busState_q <= lsc_pkg::BUS_RDDONE;
                end
                lsc_pkg::BUS_IDLE, lsc_pkg::BUS_WRITE, lsc_pkg::BUS_RDDONE: begin
                    if (addrTake) begin
                        regAddr_q  <= {haddr[7:2], 2'b00};
                        busState_q <= hwrite ? lsc_pkg::BUS_WRITE : lsc_pkg::BUS_RDWAIT;
                    end else begin
                        busState_q <= lsc_pkg::BUS_IDLE;
                    end
                end
                default: begin
                    busState_q <= lsc_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Read path
    assign strHit = (regAddr_q >= lsc_pkg::ADDR_STR) && (regAddr_q <= lsc_pkg::ADDR_STR_LAST);
    assign strIdx = regAddr_q[7:2] - lsc_pkg::ADDR_STR[7:2];

    always_comb begin
        rdMux = 32'h0000_0000;
        case (regAddr_q)
            lsc_pkg::ADDR_CTRL:     rdMux = {28'h0000000, laserOut_q, pedalMode_q,
                                             quickMode_q, aimBeam_q};
            lsc_pkg::ADDR_AUTOOFF:  rdMux = {16'h0000, autoOff_q};
            lsc_pkg::ADDR_STATUS:   rdMux = {29'h00000000, statusCode};
            lsc_pkg::ADDR_CURSET:   rdMux = {16'h0000, curSet_q};
            lsc_pkg::ADDR_CURDRV:   rdMux = {16'h0000, curDrive_q};
            lsc_pkg::ADDR_MEASCUR0: rdMux = {16'h0000, measCur0};
            lsc_pkg::ADDR_MEASCUR1: rdMux = {16'h0000, measCur1};
            lsc_pkg::ADDR_LIGHT0:   rdMux = {16'h0000, measLight0};
            lsc_pkg::ADDR_LIGHT1:   rdMux = {16'h0000, measLight1};
            lsc_pkg::ADDR_HOURS0:   rdMux = {18'h00000, hours0};
            lsc_pkg::ADDR_HOURS1:   rdMux = {18'h00000, hours1};
            lsc_pkg::ADDR_FWVER:    rdMux = lsc_pkg::FW_VERSION;
            lsc_pkg::ADDR_IRQSTAT:  rdMux = {30'h00000000, irqStat_q};
            lsc_pkg::ADDR_IRQMASK:  rdMux = {30'h00000000, irqMask_q};
            default: begin
                if (strHit) begin
                    rdMux = strMem[strIdx[4:0]];
                end
            end
        endcase
    end

    // Sampled in the wait cycle so a write just before is already visible
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_q <= 32'h0000_0000;
        end else if (clkEn && busState_q == lsc_pkg::BUS_RDWAIT) begin
            hrdata_q <= rdMux;
        end
    end

    // ==========================================================
    // Free-form strings, stored as written and never checked
    always_ff @(posedge clk_sys) begin
        if (wrEn && strHit) begin
            strMem[strIdx[4:0]] <= hwdata;
        end
    end

    // ==========================================================
    // Mode bits and current set-point
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aimBeam_q   <= 1'b0;
            quickMode_q <= 1'b0;
            pedalMode_q <= 1'b0;
            curSet_q    <= 16'h0000;
        end else if (wrEn) begin
            if (regAddr_q == lsc_pkg::ADDR_CTRL) begin
                aimBeam_q   <= hwdata[lsc_pkg::CTRL_AIM];
                quickMode_q <= hwdata[lsc_pkg::CTRL_QUICK];
                pedalMode_q <= hwdata[lsc_pkg::CTRL_PEDAL];
            end
            if (regAddr_q == lsc_pkg::ADDR_CURSET) begin
                curSet_q <= hwdata[15:0];
            end
        end
    end

    // ==========================================================
    // Current ramp
    assign rampTick = clkEn && (rampCnt_q == lsc_pkg::RAMP_LAST);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rampCnt_q  <= 9'h000;
            curDrive_q <= 16'h0000;
        end else if (clkEn) begin
            rampCnt_q <= rampTick ? 9'h000 : rampCnt_q + 9'h001;
            if (quickMode_q) begin
                curDrive_q <= curSet_q;
            end else if (rampTick && curDrive_q < curSet_q) begin
                curDrive_q <= curDrive_q + 16'h0001;
            end else if (rampTick && curDrive_q > curSet_q) begin
                curDrive_q <= curDrive_q - 16'h0001;
            end
        end
    end

    // ==========================================================
    // Seconds base and inactivity count
    assign secTick = clkEn && (secCnt_q == SEC_LAST);
    // First second after a command may be short by up to one second
    assign autoOffFire = secTick && !cmdSeen && laserOut_q && (autoOff_q != 16'h0000)
                         && (idleSec_q == autoOff_q - 16'h0001);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            secCnt_q  <= 26'h0000000;
            idleSec_q <= 16'h0000;
        end else if (clkEn) begin
            secCnt_q <= secTick ? 26'h0000000 : secCnt_q + 26'h0000001;
            if (cmdSeen) begin
                idleSec_q <= 16'h0000;
            end else if (secTick && idleSec_q != 16'hFFFF) begin
                idleSec_q <= idleSec_q + 16'h0001;
            end
        end
    end

    // ==========================================================
    // Auto-off interval, loaded from storage once after reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nvLoaded_q    <= 1'b0;
            autoOff_q     <= 16'h0000;
            nvAutoOffWr_q <= 1'b0;
        end else if (clkEn) begin
            nvLoaded_q    <= 1'b1;
            nvAutoOffWr_q <= wrEn && (regAddr_q == lsc_pkg::ADDR_AUTOOFF);
            if (!nvLoaded_q) begin
                autoOff_q <= nvAutoOff;
            end else if (wrEn && regAddr_q == lsc_pkg::ADDR_AUTOOFF) begin
                autoOff_q <= hwdata[15:0];
            end
        end
    end

    // ==========================================================
    // Foot pedal synchroniser, closed contact reads high
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pedalMeta_q <= 1'b0;
            pedalSync_q <= 1'b0;
            pedalPrev_q <= 1'b0;
        end else if (clkEn) begin
            pedalMeta_q <= pedalIn;
            pedalSync_q <= pedalMeta_q;
            pedalPrev_q <= pedalSync_q;
        end
    end

    assign pedalRise = clkEn && pedalMode_q && pedalSync_q && !pedalPrev_q;
    assign pedalFall = clkEn && pedalMode_q && !pedalSync_q && pedalPrev_q;

    // ==========================================================
    // Output state: timer beats software beats pedal
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            laserOut_q <= 1'b0;
        end else if (clkEn) begin
            if (autoOffFire) begin
                laserOut_q <= 1'b0;
            end else if (wrEn && regAddr_q == lsc_pkg::ADDR_CTRL) begin
                laserOut_q <= hwdata[lsc_pkg::CTRL_OUT];
            end else if (pedalRise) begin
                laserOut_q <= 1'b1;
            end else if (pedalFall) begin
                laserOut_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Status code: timer latch and lowest-code priority
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timerErr_q <= 1'b0;
        end else if (autoOffFire) begin
            timerErr_q <= 1'b1;
        end else if (wrEn && regAddr_q == lsc_pkg::ADDR_STATUS) begin
            timerErr_q <= 1'b0;
        end
    end

    always_comb begin
        statusCode = timerErr_q ? lsc_pkg::STATUS_TIMER : lsc_pkg::STATUS_OK;
        for (int i = 5; i >= 0; i--) begin
            if (errIn[i]) begin
                statusCode = 3'(i + 1);
            end
        end
    end

    // ==========================================================
    // Interrupts, write one to clear, new events win
    assign irqEvt = {pedalRise || pedalFall, autoOffFire};
    assign irq    = |(irqStat_q & irqMask_q);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irqStat_q <= 2'h0;
            irqMask_q <= 2'h0;
        end else if (clkEn) begin
            if (wrEn && regAddr_q == lsc_pkg::ADDR_IRQSTAT) begin
                irqStat_q <= (irqStat_q & ~hwdata[1:0]) | irqEvt;
            end else begin
                irqStat_q <= irqStat_q | irqEvt;
            end
            if (wrEn && regAddr_q == lsc_pkg::ADDR_IRQMASK) begin
                irqMask_q <= hwdata[1:0];
            end
        end
    end

    // ==========================================================
    // Hour counters, one per laser module
    assign modLoad = {2{clkEn && !nvLoaded_q}} | (modSwap & {2{clkEn}});

    lsc_hour_counter hourCnt0 (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .secTick   (secTick),
        .diodeOn   (laserOut_q),
        .nvLoad    (modLoad[0]),
        .nvHours   (modNvHours0),
        .hours_q   (hours0),
        .nvWrite_q (modNvWrite[0])
    );

    lsc_hour_counter hourCnt1 (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .secTick   (secTick),
        .diodeOn   (laserOut_q),
        .nvLoad    (modLoad[1]),
        .nvHours   (modNvHours1),
        .hours_q   (hours1),
        .nvWrite_q (modNvWrite[1])
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    ctrlWrite_a: assert property (wrEn && regAddr_q == lsc_pkg::ADDR_CTRL
        |=> aimBeam_q == $past(hwdata[0]) && quickMode_q == $past(hwdata[1]))
        else $error("mode bits did not take the written value");
    quickFollow_a: assert property (quickMode_q && clkEn |=> curDrive_q == $past(curSet_q))
        else $error("quick mode did not apply the set-point at once");
    rampStep_a: assert property (!quickMode_q && rampTick && curDrive_q < curSet_q
        |=> curDrive_q == $past(curDrive_q) + 16'h0001)
        else $error("ramp did not step by one");
    autoOff_a: assert property (autoOffFire |=> !laserOut_q && timerErr_q)
        else $error("auto-off did not shut output and post status");
    zeroOff_a: assert property (autoOff_q == 16'h0000 |-> !autoOffFire)
        else $error("auto-off fired while disabled");
    code7_a: assert property (timerErr_q && errIn == 6'h00 |-> statusCode == lsc_pkg::STATUS_TIMER)
        else $error("timer shutdown not reported as code 7");
    lowest_a: assert property (errIn[0] |-> statusCode == 3'h1)
        else $error("lowest status code not reported");
    restart_a: assert property (cmdSeen |=> idleSec_q == 16'h0000)
        else $error("command did not restart inactivity count");
    strStore_a: assert property (wrEn && strHit |=> strMem[$past(strIdx[4:0])] == $past(hwdata))
        else $error("string word not stored");
    pedalOn_a: assert property (pedalRise && !autoOffFire && !wrEn ##1 1'b1 |-> laserOut_q)
        else $error("pedal closure did not switch output on");
    measRead_a: assert property (clkEn && busState_q == lsc_pkg::BUS_RDWAIT
        && regAddr_q == lsc_pkg::ADDR_MEASCUR0 |=> hrdata == {16'h0000, $past(measCur0)})
        else $error("measured current read wrong");

endmodule

`default_nettype wire

// >>> lsc_laser_model.sv
// Laser module storage model: hour counts and auto-off interval
`default_nettype none
module lsc_laser_model (
    // Storage ports
    input  wire logic        clk_sys,
    input  wire logic        autoWr,
    input  wire logic [15:0] autoIn,
    input  wire logic [1:0]  hourWr,
    input  wire logic [13:0] hourIn0,
    input  wire logic [13:0] hourIn1,
    output logic      [15:0] autoNv,
    output logic      [13:0] hourNv0,
    output logic      [13:0] hourNv1
);
    timeunit 1ns;
    timeprecision 100ps;
    // No reset: contents outlive a power cycle
    initial begin
        autoNv = 16'h1000;
        hourNv0 = 14'h3000;
        hourNv1 = 14'h0005;
    end
    always @(posedge clk_sys) begin
        if (autoWr) autoNv <= autoIn;
        if (hourWr[0]) hourNv0 <= hourIn0;
        if (hourWr[1]) hourNv1 <= hourIn1;
    end
endmodule
`default_nettype wire

// >>> laser_serial_command_set_tb.sv
// Self-checking bench of the command interpreter core
`default_nettype none
module laser_serial_command_set_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys = 1'b0, rst_n = 1'b0, hwrite = 1'b0, pedalIn = 1'b0, en = 1'b1;
    logic        rdy, hreadyout, hresp, irq, laserOut_q, aimBeam_q, quickMode_q, nvAutoOffWr_q;
    logic [1:0]  htrans = 2'h0, modNvWrite;
    logic [5:0]  errIn = 6'h00;
    logic [13:0] nv0, nv1, hours0, hours1;
    logic [15:0] curDrive_q, autoOff_q, nvAuto, mc0 = 16'h0, mc1 = 16'h0, ml0 = 16'h0, ml1 = 16'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, q, rnd = 32'h3F;
    logic [31:0] expReg [int];
    int          errors = 0, checks_done = 0;
    always #12.5 clk_sys = ~clk_sys;
    // Bench inputs only move at rising edges, so this view is settled
    always @(negedge clk_sys) begin
        rdy = hreadyout;
        rd = hrdata;
    end
    lsc_cmd_core #(.SEC_CYCLES(20)) u_lsc_cmd_core (.clk_sys(clk_sys), .rst_n(rst_n),
        .clkEn(en), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .irq(irq), .laserOut_q(laserOut_q),
        .aimBeam_q(aimBeam_q), .quickMode_q(quickMode_q), .curDrive_q(curDrive_q),
        .measCur0(mc0), .measCur1(mc1), .measLight0(ml0), .measLight1(ml1), .errIn(errIn),
        .pedalIn(pedalIn), .nvAutoOff(nvAuto), .nvAutoOffWr_q(nvAutoOffWr_q),
        .autoOff_q(autoOff_q), .modSwap(2'h0), .modNvHours0(nv0), .modNvHours1(nv1),
        .modNvWrite(modNvWrite), .hours0(hours0), .hours1(hours1));
    lsc_laser_model u_lsc_laser_model (.clk_sys(clk_sys), .autoWr(nvAutoOffWr_q),
        .autoIn(autoOff_q), .hourWr(modNvWrite), .hourIn0(hours0), .hourIn1(hours1),
        .autoNv(nvAuto), .hourNv0(nv0), .hourNv1(nv1));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            errors++;
            $display("MISMATCH t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (rdy !== 1'b1);
        q = rd;
        if (w) expReg[a] = d;
    endtask
    task automatic rdc(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
        chk(q, expReg[a]);
    endtask
    task automatic final_report();
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #250000;
        errors++;
        final_report();
    end
    initial begin
        expReg[8'h00] = 32'h0;
        expReg[8'h04] = 32'h1000;
        expReg[8'h24] = 32'd11930;
        expReg[8'h28] = 32'h5;
        expReg[8'h38] = 32'h0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        bus(1'b1, 8'h2C, 32'h0);
        expReg[8'h2C] = lsc_pkg::FW_VERSION;
        foreach (expReg[a]) rdc(8'(a));
        rnd = lfsr(rnd);
        {mc0, mc1} <= rnd;
        ml0 <= ~rnd[15:0];
        ml1 <= 16'hFFFF;
        expReg[8'h14] = {16'h0, rnd[31:16]};
        expReg[8'h18] = {16'h0, rnd[15:0]};
        expReg[8'h1C] = {16'h0, ~rnd[15:0]};
        expReg[8'h20] = 32'hFFFF;
        for (int i = 0; i < 4; i++) rdc(8'(8'h14 + 4 * i));
        // Bytes 40 to 5F hex stay printable and never hold the separator
        for (int i = 0; i < 30; i++) begin
            rnd = lfsr(rnd);
            bus(1'b1, 8'(8'h40 + 4 * i), (rnd & 32'h1F1F1F1F) | 32'h40404040);
        end
        for (int i = 0; i < 30; i++) rdc(8'(8'h40 + 4 * i));
        bus(1'b1, 8'h00, 32'h3);
        rdc(8'h00);
        chk(32'({aimBeam_q, quickMode_q}), 32'h3);
        bus(1'b1, 8'h0C, {17'h0, rnd[14:0]});
        repeat (3) @(posedge clk_sys);
        chk(32'(curDrive_q), {17'h0, rnd[14:0]});
        bus(1'b1, 8'h00, 32'h4);
        // Set-point beyond any ramp reach, so a jump would show in bit 15
        bus(1'b1, 8'h0C, 32'h8000);
        en <= 1'b0;
        pedalIn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(32'(laserOut_q), 32'h0);
        en <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(32'(laserOut_q), 32'h1);
        pedalIn <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(32'(laserOut_q), 32'h0);
        chk(32'(curDrive_q[15]), 32'h0);
        bus(1'b1, 8'h30, 32'h3);
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h00, 32'h8);
        repeat (100) @(posedge clk_sys);
        chk(32'(laserOut_q), 32'h1);
        bus(1'b1, 8'h04, 32'h2);
        bus(1'b1, 8'h34, 32'h1);
        for (int i = 0; i < 3; i++) begin
            repeat (15) @(posedge clk_sys);
            chk(32'(laserOut_q), 32'h1);
            rdc(8'h00);
        end
        repeat (60) @(posedge clk_sys);
        chk(32'({laserOut_q, irq}), 32'h1);
        expReg[8'h00] = 32'h0;
        rdc(8'h00);
        errIn <= 6'h25;
        expReg[8'h08] = 32'h1;
        rdc(8'h08);
        errIn <= 6'h00;
        expReg[8'h08] = 32'h7;
        rdc(8'h08);
        bus(1'b1, 8'h30, 32'h1);
        @(negedge clk_sys);
        chk(32'(irq), 32'h0);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rdc(8'h04);
        final_report();
    end
endmodule
`default_nettype wire
